// >>> design/qmc_gain_calc.sv
`timescale 1ns/1ps
// Reported gain from fine read-out and population of the coarse read-outs
module qmc_gain_calc (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [6:0]  fine_in,
  input  wire logic [7:0]  coarse1_in,
  input  wire logic [6:0]  coarse2_in,
  output logic      [11:0] gain_out
);
  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  logic [3:0] pop_total;
  assign pop_total = ones8(coarse1_in) + ones8({1'b0, coarse2_in});

  // Registered so the read path sees a stable figure
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      gain_out <= 12'h0;
    end else begin
      gain_out <= {5'h0, fine_in} + {1'b0, pop_total, 7'h0}; // RL7
    end
  end

  // The first edge after reset sees the reset-time sum register, so it is skipped
  a_gain_sum: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL7
    $past(rst_n_in) |-> gain_out == 12'($past(fine_in)) + 12'(qmc_pkg::COARSE_WEIGHT) * 12'(
      $countones($past(coarse1_in)) + $countones($past(coarse2_in))))
    else $error("gain sum mismatch");
endmodule // qmc_gain_calc

// >>> design/qmc_pkg.sv
package qmc_pkg;
  // Register indices, one field group per word
  localparam logic [3:0] ADDR_W            = 4'h4;
  localparam logic [3:0] OFF_GAIN_RATIO    = 4'h0;
  localparam logic [3:0] OFF_PHASE_EXT     = 4'h1;
  localparam logic [3:0] OFF_I_TRIM        = 4'h2;
  localparam logic [3:0] OFF_Q_TRIM        = 4'h3;
  localparam logic [3:0] OFF_CONTROL       = 4'h4;
  localparam logic [3:0] OFF_BIAS          = 4'h5;
  localparam logic [3:0] OFF_FINE_GAIN     = 4'h6;
  localparam logic [3:0] OFF_THERMO        = 4'h7;
  localparam logic [3:0] OFF_GAIN_FINE_RO  = 4'h8;
  localparam logic [3:0] OFF_GAIN_C1_RO    = 4'h9;
  localparam logic [3:0] OFF_GAIN_C2_RO    = 4'ha;
  localparam logic [3:0] OFF_GAIN_TOTAL    = 4'hb;
  // Control word bit positions and the phase polarity bit
  localparam int CTL_Q_SHUTDOWN   = 0;
  localparam int CTL_SOFT_RESET   = 1;
  localparam int CTL_CORR_DISABLE = 2;
  localparam int CTL_CORR_SYNC    = 3;
  localparam int CTL_THERM_TEST   = 4;
  localparam int PHASE_POL_BIT    = 3;
  // Reset values, limits and coarse weight
  localparam logic [7:0] RST_GAIN_RATIO = 8'h80;
  localparam logic [2:0] RST_PHASE_EXT  = 3'h0;
  localparam logic [7:0] RST_DC_TRIM    = 8'h80;
  localparam logic [3:0] RST_BIAS       = 4'h4;
  localparam logic [3:0] RST_FINE_GAIN  = 4'h0;
  localparam logic [3:0] RST_THERMO     = 4'h7;
  localparam logic [3:0] THERMO_MAX     = 4'h7;
  localparam logic [6:0] RST_GAIN_FINE  = 7'h08;
  localparam logic [7:0] RST_GAIN_C1    = 8'hff;
  localparam logic [6:0] RST_GAIN_C2    = 7'h01;
  localparam logic [7:0] DC_TRIM_MIN    = 8'h01;
  localparam int unsigned COARSE_WEIGHT = 128;

  typedef struct packed {
    logic       q_shutdown;
    logic       corr_disable;
    logic       corr_sync;
    logic       therm_test;
  } qmc_ctl_s;

  typedef struct packed {
    logic [7:0] gain_ratio;
    logic [2:0] phase_ext;
    logic       phase_pol;
    logic [7:0] i_trim;
    logic [7:0] q_trim;
    logic [3:0] bias;
    logic [3:0] fine_gain;
  } qmc_trim_s;
endpackage

// >>> design/qmc_regs.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// RL1: Writing soft reset one restores every default
// RL2: Q shutdown one powers down Q path
// RL3: Read-only four-bit thermometer, max 0x07, default 0x07
// RL4: Correction disable selects manual fine gain
// RL5: Sync bit gates corrections to tick rise
// RL6: I and Q trims, 0x80 zero default
// RL7: Gain equals fine plus 128 times popcount
// RL8: Polarity bit one means positive phase extension
// RL9: Eight-bit gain ratio drives I/Q gain difference
// RL10: Three-bit phase extension widens phase range
// RL11: Software keeps thermometer test select zero
// RL12: Manual fine gain steps about 0.1 dB
// RL13: Soft reset bit clears itself
module qmc_regs (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [3:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [11:0]        reg_rdata_out,
  input  wire logic               tick_pin_in,
  input  wire logic [3:0]         die_thermo_in,
  input  wire logic [3:0]         auto_gain_in,
  input  wire logic [6:0]         dac_fine_in,
  input  wire logic [7:0]         dac_coarse1_in,
  input  wire logic [6:0]         dac_coarse2_in,
  output qmc_pkg::qmc_trim_s      trim_out,
  output qmc_pkg::qmc_ctl_s       ctl_out,
  output logic                    q_path_on_out,
  output logic [3:0]              gain_trim_out,
  output logic signed [3:0]       phase_ext_signed_out
);
  qmc_pkg::qmc_trim_s trim_reg;
  qmc_pkg::qmc_ctl_s  ctl_reg;
  logic               soft_rst_reg;
  logic [3:0]         thermo_reg;
  logic [3:0]         applied_gain_reg;
  logic [6:0]         ro_fine_reg;
  logic [7:0]         ro_c1_reg;
  logic [6:0]         ro_c2_reg;
  logic [11:0]        gain_total;
  logic               tick_level;
  logic               tick_rise;
  logic               wr_hit;

  assign wr_hit = reg_wr_in;

  // Tick pin comes from outside the clock domain
  qmc_sync3 u_tick_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (tick_pin_in),
    .level_out  (tick_level),
    .rise_out   (tick_rise)
  );

  qmc_gain_calc u_gain (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .fine_in    (ro_fine_reg),
    .coarse1_in (ro_c1_reg),
    .coarse2_in (ro_c2_reg),
    .gain_out   (gain_total)
  );

  // Soft reset pulse: set by a write of one, gone the next cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_hit && reg_addr_in == qmc_pkg::OFF_CONTROL
                      && reg_wdata_in[qmc_pkg::CTL_SOFT_RESET] && !soft_rst_reg; // RL13
    end
  end

  // Writable trims; soft reset wins over a same-cycle write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || soft_rst_reg) begin // RL1
      trim_reg.gain_ratio <= qmc_pkg::RST_GAIN_RATIO;
      trim_reg.phase_ext  <= qmc_pkg::RST_PHASE_EXT;
      trim_reg.phase_pol  <= 1'b0;
      trim_reg.i_trim     <= qmc_pkg::RST_DC_TRIM; // RL6
      trim_reg.q_trim     <= qmc_pkg::RST_DC_TRIM;
      trim_reg.bias       <= qmc_pkg::RST_BIAS;
      trim_reg.fine_gain  <= qmc_pkg::RST_FINE_GAIN;
    end else if (wr_hit) begin
      case (reg_addr_in)
        qmc_pkg::OFF_GAIN_RATIO: trim_reg.gain_ratio <= reg_wdata_in; // RL9
        qmc_pkg::OFF_PHASE_EXT: begin
          trim_reg.phase_ext <= reg_wdata_in[2:0]; // RL10
          trim_reg.phase_pol <= reg_wdata_in[qmc_pkg::PHASE_POL_BIT];
        end
        // Zero is outside the trim range, so it is ignored
        qmc_pkg::OFF_I_TRIM: begin
          if (reg_wdata_in >= qmc_pkg::DC_TRIM_MIN) begin
            trim_reg.i_trim <= reg_wdata_in; // RL6
          end
        end
        qmc_pkg::OFF_Q_TRIM: begin
          if (reg_wdata_in >= qmc_pkg::DC_TRIM_MIN) begin
            trim_reg.q_trim <= reg_wdata_in; // RL6
          end
        end
        qmc_pkg::OFF_BIAS:      trim_reg.bias <= reg_wdata_in[3:0];
        qmc_pkg::OFF_FINE_GAIN: trim_reg.fine_gain <= reg_wdata_in[3:0];
        default: begin
        end
      endcase
    end
  end

  // Control bits
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || soft_rst_reg) begin // RL1
      ctl_reg.q_shutdown   <= 1'b0; // RL2
      ctl_reg.corr_disable <= 1'b0;
      ctl_reg.corr_sync    <= 1'b1; // RL5
      ctl_reg.therm_test   <= 1'b0;
    end else if (wr_hit && reg_addr_in == qmc_pkg::OFF_CONTROL) begin
      ctl_reg.q_shutdown   <= reg_wdata_in[qmc_pkg::CTL_Q_SHUTDOWN];
      ctl_reg.corr_disable <= reg_wdata_in[qmc_pkg::CTL_CORR_DISABLE];
      ctl_reg.corr_sync    <= reg_wdata_in[qmc_pkg::CTL_CORR_SYNC];
      // Test-only bit; software is expected to leave it zero
      ctl_reg.therm_test   <= reg_wdata_in[qmc_pkg::CTL_THERM_TEST]; // RL11
    end
  end

  // Thermometer sample, clamped to the documented top code
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || soft_rst_reg) begin
      thermo_reg <= qmc_pkg::RST_THERMO; // RL3
    end else begin
      thermo_reg <= (die_thermo_in > qmc_pkg::THERMO_MAX) ?
                    qmc_pkg::THERMO_MAX : die_thermo_in; // RL3
    end
  end

  // Gain correction: manual when disabled, else tick-gated or free running
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || soft_rst_reg) begin
      applied_gain_reg <= qmc_pkg::RST_FINE_GAIN;
    end else if (ctl_reg.corr_disable) begin
      applied_gain_reg <= trim_reg.fine_gain; // RL4 RL12
    end else if (!ctl_reg.corr_sync || tick_rise) begin
      applied_gain_reg <= auto_gain_in; // RL5
    end
  end

  // DAC read-outs are sampled each cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || soft_rst_reg) begin
      ro_fine_reg <= qmc_pkg::RST_GAIN_FINE;
      ro_c1_reg   <= qmc_pkg::RST_GAIN_C1;
      ro_c2_reg   <= qmc_pkg::RST_GAIN_C2;
    end else begin
      ro_fine_reg <= dac_fine_in;
      ro_c1_reg   <= dac_coarse1_in;
      ro_c2_reg   <= dac_coarse2_in;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 12'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        qmc_pkg::OFF_GAIN_RATIO:   reg_rdata_out <= {4'h0, trim_reg.gain_ratio};
        qmc_pkg::OFF_PHASE_EXT:    reg_rdata_out <= {8'h0, trim_reg.phase_pol,
                                                     trim_reg.phase_ext};
        qmc_pkg::OFF_I_TRIM:       reg_rdata_out <= {4'h0, trim_reg.i_trim};
        qmc_pkg::OFF_Q_TRIM:       reg_rdata_out <= {4'h0, trim_reg.q_trim};
        // Soft reset bit always reads zero
        qmc_pkg::OFF_CONTROL:      reg_rdata_out <= {7'h0, ctl_reg.therm_test,
                                     ctl_reg.corr_sync, ctl_reg.corr_disable,
                                     1'b0, ctl_reg.q_shutdown}; // RL13
        qmc_pkg::OFF_BIAS:         reg_rdata_out <= {8'h0, trim_reg.bias};
        qmc_pkg::OFF_FINE_GAIN:    reg_rdata_out <= {8'h0, trim_reg.fine_gain};
        qmc_pkg::OFF_THERMO:       reg_rdata_out <= {8'h0, thermo_reg}; // RL3
        qmc_pkg::OFF_GAIN_FINE_RO: reg_rdata_out <= {5'h0, ro_fine_reg};
        qmc_pkg::OFF_GAIN_C1_RO:   reg_rdata_out <= {4'h0, ro_c1_reg};
        qmc_pkg::OFF_GAIN_C2_RO:   reg_rdata_out <= {5'h0, ro_c2_reg};
        qmc_pkg::OFF_GAIN_TOTAL:   reg_rdata_out <= gain_total; // RL7
        default:                   reg_rdata_out <= 12'h0;
      endcase
    end else begin
      reg_rdata_out <= 12'h0;
    end
  end

  // Analog-facing outputs
  assign trim_out      = trim_reg;
  assign ctl_out       = ctl_reg;
  assign q_path_on_out = !ctl_reg.q_shutdown; // RL2
  assign gain_trim_out = applied_gain_reg;
  // Sign-magnitude to two's complement; polarity one is positive
  assign phase_ext_signed_out = trim_reg.phase_pol ?
    $signed({1'b0, trim_reg.phase_ext}) : -$signed({1'b0, trim_reg.phase_ext}); // RL8

  a_soft_reset_defaults: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL1
    soft_rst_reg |=> trim_reg.i_trim == qmc_pkg::RST_DC_TRIM && ctl_reg.corr_sync
      && trim_reg.gain_ratio == qmc_pkg::RST_GAIN_RATIO && !ctl_reg.q_shutdown)
    else $error("soft reset left a field changed");

  a_soft_reset_self: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL13
    soft_rst_reg |=> !soft_rst_reg)
    else $error("soft reset did not clear");

  a_q_path_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL2
    (wr_hit && reg_addr_in == qmc_pkg::OFF_CONTROL && !soft_rst_reg
      && reg_wdata_in[qmc_pkg::CTL_Q_SHUTDOWN]) |=> !q_path_on_out)
    else $error("q path still on");

  a_thermo_range: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
    thermo_reg <= qmc_pkg::THERMO_MAX)
    else $error("thermometer above top code");

  a_manual_gain: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL4
    (ctl_reg.corr_disable && !soft_rst_reg) |=> gain_trim_out == $past(trim_reg.fine_gain))
    else $error("manual gain not applied");

  a_sync_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
    (!ctl_reg.corr_disable && ctl_reg.corr_sync && !tick_rise && !soft_rst_reg)
      |=> $stable(gain_trim_out))
    else $error("gain moved without tick");

  a_trim_nonzero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
    trim_reg.i_trim != 8'h00 && trim_reg.q_trim != 8'h00)
    else $error("trim left valid range");

  a_phase_sign: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
    (trim_reg.phase_pol && trim_reg.phase_ext != 3'h0) |-> phase_ext_signed_out > 0)
    else $error("phase sign wrong");

  a_ratio_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL9
    (wr_hit && reg_addr_in == qmc_pkg::OFF_GAIN_RATIO && !soft_rst_reg)
      |=> trim_out.gain_ratio == $past(reg_wdata_in))
    else $error("gain ratio not stored");

  a_read_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!reg_rd_in ##1 1'b1) |-> reg_rdata_out == 12'h0)
    else $error("read data without strobe");

  // Field stores; a write in the soft reset cycle is lost on purpose
  a_phase_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL10
    (wr_hit && reg_addr_in == qmc_pkg::OFF_PHASE_EXT && !soft_rst_reg)
      |=> trim_out.phase_ext == $past(reg_wdata_in[2:0]))
    else $error("phase extension not stored");

  a_phase_pol_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
    (wr_hit && reg_addr_in == qmc_pkg::OFF_PHASE_EXT && !soft_rst_reg)
      |=> trim_out.phase_pol == $past(reg_wdata_in[qmc_pkg::PHASE_POL_BIT]))
    else $error("phase polarity not stored");

  a_phase_negative: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
    (!trim_reg.phase_pol && trim_reg.phase_ext != 3'h0) |-> phase_ext_signed_out < 0)
    else $error("negative phase sign wrong");

  a_phase_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL10
    (trim_reg.phase_ext == 3'h0) |-> phase_ext_signed_out == 4'sh0)
    else $error("zero phase extension not zero");

  a_i_trim_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
    (wr_hit && reg_addr_in == qmc_pkg::OFF_I_TRIM && reg_wdata_in != 8'h00 && !soft_rst_reg)
      |=> trim_reg.i_trim == $past(reg_wdata_in))
    else $error("i trim not stored");

  a_q_trim_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
    (wr_hit && reg_addr_in == qmc_pkg::OFF_Q_TRIM && reg_wdata_in != 8'h00 && !soft_rst_reg)
      |=> trim_reg.q_trim == $past(reg_wdata_in))
    else $error("q trim not stored");

  a_i_trim_refuse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
    (wr_hit && reg_addr_in == qmc_pkg::OFF_I_TRIM && reg_wdata_in == 8'h00 && !soft_rst_reg)
      |=> $stable(trim_reg.i_trim))
    else $error("i trim took zero");

  a_q_trim_refuse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
    (wr_hit && reg_addr_in == qmc_pkg::OFF_Q_TRIM && reg_wdata_in == 8'h00 && !soft_rst_reg)
      |=> $stable(trim_reg.q_trim))
    else $error("q trim took zero");

  a_fine_gain_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL12
    (wr_hit && reg_addr_in == qmc_pkg::OFF_FINE_GAIN && !soft_rst_reg)
      |=> trim_reg.fine_gain == $past(reg_wdata_in[3:0]))
    else $error("fine gain not stored");

  // Control word behaviour
  a_q_path_on: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL2
    (wr_hit && reg_addr_in == qmc_pkg::OFF_CONTROL && !soft_rst_reg
      && !reg_wdata_in[qmc_pkg::CTL_Q_SHUTDOWN]) |=> q_path_on_out)
    else $error("q path still off");

  a_soft_reset_take: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL13
    (wr_hit && reg_addr_in == qmc_pkg::OFF_CONTROL && !soft_rst_reg
      && reg_wdata_in[qmc_pkg::CTL_SOFT_RESET]) |=> soft_rst_reg)
    else $error("soft reset not taken");

  a_soft_reset_rest: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL1
    soft_rst_reg |=> !ctl_reg.corr_disable && !ctl_reg.therm_test && !trim_reg.phase_pol
      && trim_reg.bias == qmc_pkg::RST_BIAS && trim_reg.fine_gain == qmc_pkg::RST_FINE_GAIN
      && trim_reg.phase_ext == qmc_pkg::RST_PHASE_EXT && trim_reg.q_trim == qmc_pkg::RST_DC_TRIM)
    else $error("soft reset left a field changed");

  a_ctl_read_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL13
    (reg_rd_in && reg_addr_in == qmc_pkg::OFF_CONTROL) |=> !reg_rdata_out[qmc_pkg::CTL_SOFT_RESET])
    else $error("soft reset bit read as one");

  // Thermometer, gain correction and gain total read paths
  a_thermo_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
    (die_thermo_in <= qmc_pkg::THERMO_MAX && !soft_rst_reg)
      |=> thermo_reg == $past(die_thermo_in))
    else $error("thermometer did not follow");

  a_thermo_clamp: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
    (die_thermo_in > qmc_pkg::THERMO_MAX && !soft_rst_reg)
      |=> thermo_reg == qmc_pkg::THERMO_MAX)
    else $error("thermometer not clamped");

  a_free_update: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
    (!ctl_reg.corr_disable && !ctl_reg.corr_sync && !soft_rst_reg)
      |=> gain_trim_out == $past(auto_gain_in))
    else $error("free correction not applied");

  a_tick_update: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
    (!ctl_reg.corr_disable && ctl_reg.corr_sync && tick_rise && !soft_rst_reg)
      |=> gain_trim_out == $past(auto_gain_in))
    else $error("tick correction not applied");

  a_total_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL7
    (reg_rd_in && reg_addr_in == qmc_pkg::OFF_GAIN_TOTAL) |=> reg_rdata_out == $past(gain_total))
    else $error("gain total read wrong");
endmodule // qmc_regs

// >>> design/qmc_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module qmc_sync3 (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic [2:0] sync_reg;
  logic       level_reg;

  // Stage one is read only by stage two
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], async_in};
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
    end
  end

  assign level_out = level_reg;
  assign rise_out  = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
endmodule // qmc_sync3

// >>> verification/qmc_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the modulator control register bank
module qmc_regs_tb;
  logic               sys_clk_in = 1'b0;
  logic               rst_n_in = 1'b0;
  logic [3:0]         reg_addr_in = 4'h0;
  logic [7:0]         reg_wdata_in = 8'h00;
  logic               reg_wr_in = 1'b0;
  logic               reg_rd_in = 1'b0;
  logic [11:0]        reg_rdata_out;
  logic               tick_pin_in = 1'b0;
  logic [3:0]         die_thermo_in = 4'h7;
  logic [3:0]         auto_gain_in = 4'h0;
  logic [6:0]         dac_fine_in = 7'h08;
  logic [7:0]         dac_coarse1_in = 8'hff;
  logic [6:0]         dac_coarse2_in = 7'h01;
  qmc_pkg::qmc_trim_s trim_out;
  qmc_pkg::qmc_ctl_s  ctl_out;
  logic               q_path_on_out;
  logic [3:0]         gain_trim_out;
  logic signed [3:0]  phase_ext_signed_out;
  logic [11:0]        exp_q[$];
  logic               rd_d = 1'b0;
  int                 n_fail = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  logic [7:0]         v [0:6];
  logic [3:0]         e;
  logic [11:0]        g;

  // 250 MHz system clock
  always #2 sys_clk_in = ~sys_clk_in;

  qmc_regs dut (
    .sys_clk_in          (sys_clk_in),
    .rst_n_in            (rst_n_in),
    .reg_addr_in         (reg_addr_in),
    .reg_wdata_in        (reg_wdata_in),
    .reg_wr_in           (reg_wr_in),
    .reg_rd_in           (reg_rd_in),
    .reg_rdata_out       (reg_rdata_out),
    .tick_pin_in         (tick_pin_in),
    .die_thermo_in       (die_thermo_in),
    .auto_gain_in        (auto_gain_in),
    .dac_fine_in         (dac_fine_in),
    .dac_coarse1_in      (dac_coarse1_in),
    .dac_coarse2_in      (dac_coarse2_in),
    .trim_out            (trim_out),
    .ctl_out             (ctl_out),
    .q_path_on_out       (q_path_on_out),
    .gain_trim_out       (gain_trim_out),
    .phase_ext_signed_out(phase_ext_signed_out)
  );

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus cycle; every strobe is set afresh so back-to-back cycles never double-drive
  task automatic op(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
    reg_wr_in <= wr;
    reg_rd_in <= rd;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  // The expected word is queued before the strobe so the watcher finds it in order
  task automatic rd(input logic [3:0] a, input logic [11:0] exp);
    exp_q.push_back(exp);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 4'h0, 8'h00);
  endtask

  // Every writable word plus thermometer and gain total at their defaults
  task automatic defaults();
    rd(4'h0, {4'h0, qmc_pkg::RST_GAIN_RATIO});
    rd(4'h1, 12'h000);
    rd(4'h2, {4'h0, qmc_pkg::RST_DC_TRIM});
    rd(4'h3, {4'h0, qmc_pkg::RST_DC_TRIM});
    rd(4'h4, 12'h008);
    rd(4'h5, {8'h00, qmc_pkg::RST_BIAS});
    rd(4'h6, {8'h00, qmc_pkg::RST_FINE_GAIN});
    rd(4'h7, {8'h00, qmc_pkg::RST_THERMO});
    rd(4'hb, 12'h488);
    idle(1);
    check("q path on", {39'h0, q_path_on_out}, 40'h1);
    check("phase signed", {36'h0, phase_ext_signed_out}, 40'h0);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there
  always @(posedge sys_clk_in) begin
    rd_d <= reg_rd_in;
    cycles <= cycles + 1;
    if (rd_d) check("read data", {28'h0, reg_rdata_out}, {28'h0, exp_q.pop_front()});
    if (cycles == 4000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(31612));
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    idle(4);
    defaults();
    // Random writable values, both polarities of the phase extension
    for (int k = 0; k < 2; k++) begin
      foreach (v[i]) v[i] = 8'($urandom_range(255, 1));
      v[1] = {4'h0, k[0], v[1][2:0]};
      v[5] = 8'($urandom_range(13, 0));
      v[6] = {4'h0, v[6][3:0]};
      foreach (v[i]) if (i != 4) wr(4'(i), v[i]);
      foreach (v[i]) if (i != 4) rd(4'(i), {4'h0, v[i]});
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      rd(4'h2, {4'h0, v[2]});
      rd(4'h3, {4'h0, v[3]});
      idle(1);
      check("trim", {4'h0, trim_out},
            {4'h0, v[0], v[1][2:0], v[1][3], v[2], v[3], v[5][3:0], v[6][3:0]});
      e = v[1][3] ? {1'b0, v[1][2:0]} : 4'h0 - {1'b0, v[1][2:0]};
      check("phase signed", {36'h0, phase_ext_signed_out}, {36'h0, e});
    end
    // Q shutdown with sync kept; the test-select bit stays zero
    wr(4'h4, 8'h09);
    rd(4'h4, 12'h009);
    idle(1);
    check("ctl", {36'h0, ctl_out}, 40'ha);
    check("q path on", {39'h0, q_path_on_out}, 40'h0);
    // Thermometer follows the sensor and clamps at its ceiling
    die_thermo_in <= 4'hc;
    idle(4);
    rd(4'h7, 12'h007);
    die_thermo_in <= 4'($urandom_range(7, 0));
    idle(4);
    rd(4'h7, {8'h00, die_thermo_in});
    // Read-outs and the total built from their set-bit count
    repeat (3) begin
      dac_fine_in <= 7'($urandom);
      dac_coarse1_in <= 8'($urandom);
      dac_coarse2_in <= 7'($urandom);
      idle(5);
      g = 12'(dac_fine_in) + 12'd128 * 12'($countones({dac_coarse1_in, dac_coarse2_in}));
      rd(4'h8, {5'h00, dac_fine_in});
      rd(4'h9, {4'h0, dac_coarse1_in});
      rd(4'ha, {5'h00, dac_coarse2_in});
      rd(4'hb, g);
    end
    // Manual gain, free-running correction, then tick-gated correction
    wr(4'h4, 8'h04);
    idle(6);
    check("manual gain", {36'h0, gain_trim_out}, {36'h0, v[6][3:0]});
    wr(4'h4, 8'h00);
    auto_gain_in <= 4'h5;
    idle(6);
    check("auto gain", {36'h0, gain_trim_out}, 40'h5);
    wr(4'h4, 8'h08);
    auto_gain_in <= 4'ha;
    idle(8);
    check("gated gain hold", {36'h0, gain_trim_out}, 40'h5);
    tick_pin_in <= 1'b1;
    idle(8);
    check("gated gain tick", {36'h0, gain_trim_out}, 40'ha);
    tick_pin_in <= 1'b0;
    // Unmapped words read zero
    for (int a = 12; a < 16; a++) rd(4'(a), 12'h000);
    // Soft reset in the same word as other bits; everything returns to default
    dac_fine_in <= 7'h08;
    dac_coarse1_in <= 8'hff;
    dac_coarse2_in <= 7'h01;
    die_thermo_in <= 4'h7;
    wr(4'h4, 8'h07);
    idle(4);
    defaults();
    idle(3);
    stop_test();
  end
endmodule // qmc_regs_tb
